// ### logic/sdc_core.sv
// Purpose: Serial header decoder, register space, command strobes, synth calibration
// Assumes: Host is serial master, mode 0, MSB first; serial pins are asynchronous
// Notes:   Radio datapath is outside; received bytes arrive on i_rx_valid/i_rx_byte
// What this block does
// [R1] Strobe addresses trigger actions, not storage
// [R2] Forty-two 8-bit writable configuration registers
// [R3] Configuration registers reset to defaults
// [R4] Host rewrites non-default registers after reset
// [R5] Unused configuration addresses accept dummy writes
// [R6] Two read-only status registers ignore writes
// [R7] FIFO read at one address pops bytes
// [R8] Status byte returned during header and writes
// [R9] Burst bit means status read above 0x2F
// [R10] Oscillator-off strobe stops crystal
// [R11] Calibrate strobe calibrates then turns synth off
// [R12] Receive strobe from idle, autocalibrate first
// [R13] Power-down happens when chip select rises
// [R14] Flush strobe empties receive FIFO
// [R15] Host flushes only in idle or overflow
// [R16] No-op strobe only returns status
// [R17] Full calibration lasts 712/724 us
// [R18] Restored results need 75 us turn-on
// [R19] Charge pump cal disabled shortens calibration
// [R20] Test setting lost through sleep
// [R21] Reserved strobes do nothing, return status
`timescale 1ns/1ps
module sdc_core #(
    parameter int FIFO_DEPTH = 64,                  // Receive FIFO bytes
    parameter int CAL_FULL   = sdc_pkg::CAL_FULL_CYC,
    parameter int CAL_FULL_A = sdc_pkg::CAL_FULL_ALT_CYC,
    parameter int CAL_SHORT  = sdc_pkg::CAL_SHORT_CYC,
    parameter int CAL_SHORT_A = sdc_pkg::CAL_SHORT_ALT_CYC,
    parameter int SYNTH_ON   = sdc_pkg::SYNTH_ON_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_sclk,                  // Serial clock pin
    input  wire logic       i_serial_chip_select_n,  // Serial select pin
    input  wire logic       i_mosi,                  // Serial data in
    output logic            o_miso,                  // Serial data out
    input  wire logic       i_rx_valid,              // Received byte strobe
    input  wire logic [7:0] i_rx_byte,               // Received byte
    output logic            o_xosc_on,               // Crystal oscillator enabled
    output logic            o_synth_on,              // Synthesizer powered
    output logic            o_rx_on,                 // Receiver enabled
    output logic            o_cal_busy,              // Calibration running
    output logic            o_sleep,                 // Power-down state
    output sdc_pkg::sdc_state_t o_state              // Main state
);
    import sdc_pkg::*;

    localparam int CW = 18;                          // Calibration counter width
    localparam int AW = $clog2(FIFO_DEPTH);

    // Elaboration checks on parameters
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || FIFO_DEPTH > 64)
        $error("FIFO_DEPTH must be a power of two from 2 to 64");
    if (CAL_FULL_A >= (1 << CW) || CAL_FULL < 1 || CAL_SHORT < 1 || SYNTH_ON < 1)
        $error("Calibration counts out of range");

    // Three-stage synchronisers on the serial pins
    logic [2:0] sclk_s_r;
    logic [2:0] csn_s_r;
    logic [2:0] mosi_s_r;
    logic       sclk_q_r;                            // Filtered levels
    logic       csn_q_r;
    logic       mosi_q_r;

    // Shift engine
    logic [2:0] bit_cnt_r;                           // Bit within byte
    logic [7:0] shin_r;                              // Incoming byte
    logic [7:0] shout_r;                             // Outgoing byte
    logic       hdr_done_r;                          // Header already taken
    logic [5:0] addr_r;                              // Current access address
    logic       rd_r;                                // Read access
    logic       burst_r;                             // Burst access
    logic       pwd_pend_r;                          // Power-down armed until select rises

    // Register storage, decoded on full address range
    logic [7:0] cfg_r [0:47];                        // Configuration array
    logic [7:0] fifo_r [0:FIFO_DEPTH-1];             // Receive FIFO
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    sdc_state_t  state_r;
    logic [CW-1:0] cal_cnt_r;                        // Calibration/settle countdown
    logic        cal_to_rx_r;                        // Enter receive when done

    // Filtered pin edges: change counts once stages 2 and 3 agree
    wire sclk_rise = (sclk_s_r[1] == sclk_s_r[2]) && sclk_s_r[2] && !sclk_q_r;
    wire sclk_fall = (sclk_s_r[1] == sclk_s_r[2]) && !sclk_s_r[2] && sclk_q_r;
    wire csn_rise  = (csn_s_r[1] == csn_s_r[2]) && csn_s_r[2] && !csn_q_r;
    wire byte_done = sclk_rise && !csn_q_r && (bit_cnt_r == 3'd7);
    wire [7:0] full_byte = {shin_r[6:0], mosi_q_r};
    wire fifo_count_ok = (wr_ptr_r != rd_ptr_r);
    wire [AW:0] fifo_level = wr_ptr_r - rd_ptr_r;

    // Configuration address is one of the 42 real registers
    function automatic logic is_cfg(input logic [5:0] a);
        is_cfg = (a <= CFG_LAST) && a != 6'h1E && a != 6'h1F && a != 6'h22
                 && a != 6'h27 && a != 6'h28;
    endfunction : is_cfg

    // Status byte: ready-n, state, FIFO level
    function automatic logic [7:0] status_byte(input sdc_state_t s, input logic [AW:0] lvl);
        logic [2:0] st;
        st = 3'd0;
        unique case (s)
            SDC_RX:       st = 3'd1;
            SDC_CAL, SDC_SETTLE: st = 3'd4;
            SDC_OVERFLOW: st = 3'd6;
            default:      st = 3'd0;
        endcase
        status_byte = {(s == SDC_XOFF || s == SDC_SLEEP), st,
                       (lvl > 15) ? 4'hF : lvl[3:0]};
    endfunction : status_byte

    // Read-only status registers; writes never land here
    function automatic logic [7:0] status_reg(input logic [5:0] a);
        status_reg = 8'h00;
        if (a == STATE_STATUS_ADDR)
            status_reg = {5'h00, state_r};                  // [R6]
        else if (a == RXBYTES_STATUS_ADDR)
            status_reg = {(state_r == SDC_OVERFLOW), 7'(fifo_level)}; // [R6]
    endfunction : status_reg

    // Pin synchronisers and filtered levels
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sclk_s_r <= 3'b000;
            csn_s_r  <= 3'b111;
            mosi_s_r <= 3'b000;
            sclk_q_r <= 1'b0;
            csn_q_r  <= 1'b1;
            mosi_q_r <= 1'b0;
        end
        else
        begin
            sclk_s_r <= {sclk_s_r[1:0], i_sclk};
            csn_s_r  <= {csn_s_r[1:0], i_serial_chip_select_n};
            mosi_s_r <= {mosi_s_r[1:0], i_mosi};
            if (sclk_s_r[1] == sclk_s_r[2])
                sclk_q_r <= sclk_s_r[2];
            if (csn_s_r[1] == csn_s_r[2])
                csn_q_r <= csn_s_r[2];
            if (mosi_s_r[1] == mosi_s_r[2])
                mosi_q_r <= mosi_s_r[2];
        end
    end

    // Shift engine and header decode
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            bit_cnt_r  <= 3'd0;
            shin_r     <= 8'h00;
            shout_r    <= 8'h00;
            hdr_done_r <= 1'b0;
            addr_r     <= 6'h00;
            rd_r       <= 1'b0;
            burst_r    <= 1'b0;
            o_miso     <= 1'b0;
        end
        else if (csn_q_r)
        begin
            // Deselected: restart framing, preload status for next header
            bit_cnt_r  <= 3'd0;
            hdr_done_r <= 1'b0;
            shout_r    <= status_byte(state_r, fifo_level);  // [R8]
            o_miso     <= 1'b0;
        end
        else if (sclk_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            shin_r    <= full_byte;
            if (byte_done && !hdr_done_r)
            begin
                hdr_done_r <= 1'b1;
                addr_r     <= full_byte[5:0];
                rd_r       <= full_byte[HDR_RW_BIT];
                burst_r    <= full_byte[HDR_BURST_BIT];
            end
            else if (byte_done && burst_r && addr_r < STROBE_BASE)
                addr_r <= addr_r + 6'd1;                     // Burst steps through config
        end
        else if (sclk_fall)
        begin
            // Load next outgoing byte at byte boundary, else shift
            if (bit_cnt_r == 3'd0 && hdr_done_r)
            begin
                if (!rd_r)
                    shout_r <= status_byte(state_r, fifo_level);   // [R8]
                else if (addr_r == FIFO_ADDR)
                    shout_r <= fifo_r[rd_ptr_r[AW-1:0]];           // [R7]
                else if (addr_r >= STROBE_BASE && burst_r)
                    shout_r <= status_reg(addr_r);                 // [R9]
                else if (addr_r >= STROBE_BASE)
                    shout_r <= status_byte(state_r, fifo_level);
                else
                    shout_r <= cfg_r[addr_r];
            end
            else
                shout_r <= {shout_r[6:0], 1'b0};
        end
        else
            o_miso <= shout_r[7];                            // Bit stands before next rise [R8]
    end

    // Decoded actions taken at end of a byte
    wire is_hdr     = byte_done && !hdr_done_r;
    wire strobe_hit = is_hdr && full_byte[5:0] >= STROBE_BASE && !full_byte[HDR_BURST_BIT]
                      && full_byte[5:0] != FIFO_ADDR;                 // [R9]
    wire [5:0] strobe_code = full_byte[5:0];
    wire cfg_write  = byte_done && hdr_done_r && !rd_r && addr_r < STROBE_BASE;
    wire fifo_pop   = byte_done && hdr_done_r && rd_r && addr_r == FIFO_ADDR && fifo_count_ok;
    wire do_reset   = strobe_hit && strobe_code == CHIP_RESET_STROBE;  // [R1]
    wire do_flush   = strobe_hit && strobe_code == FIFO_FLUSH_STROBE;
    wire autocal    = cfg_r[AUTOCAL_CTRL_ADDR][AUTOCAL_LSB +: 2] != 2'b00;
    wire cp_cal_en  = cfg_r[CHARGE_PUMP_CAL_RESULT][CP_CAL_LSB +: 2] != 2'b00;
    wire alt_test   = cfg_r[SYNTH_TEST_SETTING][OSC_SEL_CAL_EN_BIT];

    // Calibration length from options
    function automatic logic [CW-1:0] cal_len(input logic cp, input logic alt);
        if (cp)
            cal_len = alt ? CW'(CAL_FULL_A) : CW'(CAL_FULL);       // [R17]
        else
            cal_len = alt ? CW'(CAL_SHORT_A) : CW'(CAL_SHORT);     // [R19]
    endfunction : cal_len

    // Configuration registers; unused and reserved addresses absorb writes
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < 48; i++)
                cfg_r[i] <= (i == int'(SYNTH_TEST_SETTING)) ? SYNTH_TEST_RESET
                                                           : CFG_RESET_DEFAULT; // [R3]
        end
        else if (do_reset)
        begin
            // Chip reset strobe restores every default
            for (int i = 0; i < 48; i++)
                cfg_r[i] <= (i == int'(SYNTH_TEST_SETTING)) ? SYNTH_TEST_RESET
                                                           : CFG_RESET_DEFAULT; // [R1] [R3]
        end
        else
        begin
            if (cfg_write && is_cfg(addr_r))
                cfg_r[addr_r] <= full_byte;                                   // [R2] [R18]
            // Dummy writes to unused addresses are dropped  [R5]
            if (state_r == SDC_SLEEP)
                cfg_r[SYNTH_TEST_SETTING] <= SYNTH_TEST_RESET;                // [R20]
        end
    end

    // Receive FIFO storage, single address access
    always_ff @(posedge i_clk)
    begin
        if (i_rx_valid && state_r == SDC_RX && fifo_level != (AW+1)'(FIFO_DEPTH))
            fifo_r[wr_ptr_r[AW-1:0]] <= i_rx_byte;
    end

    // FIFO pointers, flush on strobe
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else if (do_flush || do_reset)
        begin
            wr_ptr_r <= '0;                                   // [R14]
            rd_ptr_r <= '0;                                   // [R14]
        end
        else
        begin
            if (i_rx_valid && state_r == SDC_RX && fifo_level != (AW+1)'(FIFO_DEPTH))
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (fifo_pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;                  // [R7]
        end
    end

    // Main state machine driven by strobes; reserved codes fall through  [R21] [R16]
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_r     <= SDC_IDLE;
            cal_cnt_r   <= '0;
            cal_to_rx_r <= 1'b0;
            pwd_pend_r  <= 1'b0;
        end
        else if (do_reset)
        begin
            state_r     <= SDC_IDLE;                          // [R1]
            cal_cnt_r   <= '0;
            cal_to_rx_r <= 1'b0;
            pwd_pend_r  <= 1'b0;
        end
        else if (strobe_hit)
        begin
            unique case (strobe_code)
                GO_IDLE_STROBE:
                begin
                    state_r    <= SDC_IDLE;                   // [R1]
                    pwd_pend_r <= 1'b0;
                end
                OSCILLATOR_OFF_STROBE:
                    state_r <= SDC_XOFF;                      // [R10]
                SYNTH_CALIBRATE_STROBE:
                    if (state_r == SDC_IDLE)
                    begin
                        state_r     <= SDC_CAL;               // [R11]
                        cal_cnt_r   <= cal_len(cp_cal_en, alt_test);
                        cal_to_rx_r <= 1'b0;
                    end
                RECEIVE_ENABLE_STROBE:
                    if (state_r == SDC_IDLE && autocal)
                    begin
                        state_r     <= SDC_CAL;               // [R12]
                        cal_cnt_r   <= cal_len(cp_cal_en, alt_test);
                        cal_to_rx_r <= 1'b1;
                    end
                    else if (state_r == SDC_IDLE)
                    begin
                        state_r   <= SDC_SETTLE;              // [R18]
                        cal_cnt_r <= CW'(SYNTH_ON);
                    end
                POWER_DOWN_STROBE:
                    pwd_pend_r <= 1'b1;                       // [R13]
                default:
                    state_r <= state_r;                       // [R16] [R21]
            endcase
        end
        else if (csn_rise && pwd_pend_r)
        begin
            state_r    <= SDC_SLEEP;                          // [R13]
            pwd_pend_r <= 1'b0;
        end
        else if (state_r == SDC_XOFF && csn_rise)
            state_r <= SDC_IDLE;                              // Oscillator restarts when select rises
        else if (state_r == SDC_SLEEP && !csn_q_r)
            state_r <= SDC_IDLE;                              // Wake on select low
        else if (state_r == SDC_CAL || state_r == SDC_SETTLE)
        begin
            if (cal_cnt_r > CW'(1))
                cal_cnt_r <= cal_cnt_r - CW'(1);
            else if (state_r == SDC_CAL && cal_to_rx_r)
            begin
                state_r   <= SDC_SETTLE;                      // Turn synth on after cal
                cal_cnt_r <= CW'(SYNTH_ON);
            end
            else if (state_r == SDC_CAL)
                state_r <= SDC_IDLE;                          // [R11]
            else
                state_r <= SDC_RX;                            // [R12]
        end
        else if (state_r == SDC_RX && i_rx_valid
                 && fifo_level == (AW+1)'(FIFO_DEPTH))
            state_r <= SDC_OVERFLOW;                          // [R15]
        else if (state_r == SDC_OVERFLOW && do_flush)
            state_r <= SDC_IDLE;
    end

    // Registered control outputs
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_xosc_on  <= 1'b1;
            o_synth_on <= 1'b0;
            o_rx_on    <= 1'b0;
            o_cal_busy <= 1'b0;
            o_sleep    <= 1'b0;
            o_state    <= SDC_IDLE;
        end
        else
        begin
            o_xosc_on  <= !(state_r == SDC_XOFF || state_r == SDC_SLEEP);  // [R10]
            o_synth_on <= state_r == SDC_SETTLE || state_r == SDC_RX;
            o_rx_on    <= state_r == SDC_RX;
            o_cal_busy <= state_r == SDC_CAL;
            o_sleep    <= state_r == SDC_SLEEP;
            o_state    <= state_r;
        end
    end

endmodule : sdc_core

// ### logic/sdc_pkg.sv
// Purpose: Shared constants for the serial strobe decoder and calibration control
// Assumes: 200 MHz system clock
// Notes:   Offsets are serial header base addresses
package sdc_pkg;

    // Header byte flag bits
    localparam int       HDR_RW_BIT      = 7;
    localparam int       HDR_BURST_BIT   = 6;
    localparam logic [5:0] STROBE_BASE   = 6'h30;   // Bases at or above are strobes/status
    localparam logic [5:0] CFG_LAST      = 6'h2E;   // Last configuration address
    localparam logic [5:0] FIFO_ADDR     = 6'h3F;   // Receive FIFO address

    // Strobe offsets
    localparam logic [5:0] CHIP_RESET_STROBE      = 6'h30;
    localparam logic [5:0] OSCILLATOR_OFF_STROBE  = 6'h32;
    localparam logic [5:0] SYNTH_CALIBRATE_STROBE = 6'h33;
    localparam logic [5:0] RECEIVE_ENABLE_STROBE  = 6'h34;
    localparam logic [5:0] GO_IDLE_STROBE         = 6'h36;
    localparam logic [5:0] POWER_DOWN_STROBE      = 6'h39;
    localparam logic [5:0] FIFO_FLUSH_STROBE      = 6'h3A;
    localparam logic [5:0] NO_OPERATION_STROBE    = 6'h3D;

    // Calibration and test registers
    localparam logic [5:0] AUTOCAL_CTRL_ADDR      = 6'h18;
    localparam int         AUTOCAL_LSB            = 4;  // Two-bit field, nonzero enables
    localparam logic [5:0] CHARGE_PUMP_CAL_RESULT = 6'h23;
    localparam logic [5:0] VCO_CURRENT_CAL_RESULT = 6'h24;
    localparam logic [5:0] VCO_CAP_CAL_RESULT     = 6'h25;
    localparam logic [5:0] SYNTH_TEST_SETTING     = 6'h2E;
    localparam int         CP_CAL_LSB             = 4;
    localparam int         OSC_SEL_CAL_EN_BIT     = 1;
    localparam logic [7:0] SYNTH_TEST_RESET       = 8'h09;
    localparam logic [7:0] CFG_RESET_DEFAULT      = 8'h00;

    // Status register offsets
    localparam logic [5:0] STATUS_FIRST           = 6'h30;
    localparam logic [5:0] STATE_STATUS_ADDR      = 6'h35;
    localparam logic [5:0] RXBYTES_STATUS_ADDR    = 6'h3B;

    // Calibration times in ns
    localparam int CAL_FULL_NS       = 712000;
    localparam int CAL_FULL_ALT_NS   = 724000;
    localparam int CAL_SHORT_NS      = 145000;
    localparam int CAL_SHORT_ALT_NS  = 157000;
    localparam int SYNTH_ON_NS       = 75000;
    localparam int CLK_PERIOD_NS     = 5;
    localparam int CAL_FULL_CYC      = CAL_FULL_NS / CLK_PERIOD_NS;
    localparam int CAL_FULL_ALT_CYC  = CAL_FULL_ALT_NS / CLK_PERIOD_NS;
    localparam int CAL_SHORT_CYC     = CAL_SHORT_NS / CLK_PERIOD_NS;
    localparam int CAL_SHORT_ALT_CYC = CAL_SHORT_ALT_NS / CLK_PERIOD_NS;
    localparam int SYNTH_ON_CYC      = SYNTH_ON_NS / CLK_PERIOD_NS;

    // Main radio states
    typedef enum logic [2:0]
    {
        SDC_IDLE,
        SDC_CAL,
        SDC_SETTLE,
        SDC_RX,
        SDC_OVERFLOW,
        SDC_XOFF,
        SDC_SLEEP
    } sdc_state_t;

endpackage : sdc_pkg

// ### tb/sdc_core_props.sv
// Purpose: Port-level checks on the strobe decoder state outputs
// Assumes: One 200 MHz domain, asynchronous active-high reset
// Notes:   Counters bound calibration and settle stays
`timescale 1ns/1ps
module sdc_core_props #(
    parameter int CAL_FULL_A = 44,                        // Longest calibration
    parameter int SYNTH_ON   = 5                          // Synth turn-on stay
) (
    input wire logic                i_clk,
    input wire logic                i_reset,
    input wire logic                i_serial_chip_select_n,
    input wire logic                o_miso,
    input wire logic                o_xosc_on,
    input wire logic                o_synth_on,
    input wire logic                o_rx_on,
    input wire logic                o_cal_busy,
    input wire logic                o_sleep,
    input wire sdc_pkg::sdc_state_t o_state
);
    import sdc_pkg::*;
    int cal_cnt_r;                                        // Cycles in calibration
    int set_cnt_r;                                        // Cycles settling
    // Run lengths; stays this long cannot be unrolled as repetitions
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset) cal_cnt_r <= 0;
        else cal_cnt_r <= o_cal_busy ? cal_cnt_r + 1 : 0;
    end
    // Settle stay counter
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset) set_cnt_r <= 0;
        else set_cnt_r <= (o_state == SDC_SETTLE) ? set_cnt_r + 1 : 0;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_cal_len; cal_cnt_r <= CAL_FULL_A; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration too long");
    property p_set_len; set_cnt_r <= SYNTH_ON; endproperty
    a_set_len: assert property (p_set_len) else $error("settle too long");
    property p_flags; o_rx_on == (o_state == SDC_RX) && o_cal_busy == (o_state == SDC_CAL);
    endproperty
    a_flags: assert property (p_flags) else $error("rx or cal flag wrong");
    property p_xosc; o_xosc_on == !(o_state inside {SDC_XOFF, SDC_SLEEP}); endproperty
    a_xosc: assert property (p_xosc) else $error("oscillator flag wrong");
    property p_synth; o_synth_on == (o_state inside {SDC_SETTLE, SDC_RX}); endproperty
    a_synth: assert property (p_synth) else $error("synth flag wrong");
    property p_cal_exit; $fell(o_cal_busy) |-> o_state inside {SDC_IDLE, SDC_SETTLE};
    endproperty
    a_cal_exit: assert property (p_cal_exit) else $error("bad exit from cal");
    property p_rx_entry; $rose(o_rx_on) |-> $past(o_state) == SDC_SETTLE; endproperty
    a_rx_entry: assert property (p_rx_entry) else $error("rx without settle");
    property p_sleep_in; $rose(o_sleep) |-> i_serial_chip_select_n; endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep while selected");
    property p_sleep_out; $fell(o_sleep) |-> !i_serial_chip_select_n && o_state == SDC_IDLE;
    endproperty
    a_sleep_out: assert property (p_sleep_out) else $error("bad wake");
    property p_miso_idle; i_serial_chip_select_n [*8] |-> !o_miso; endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("miso set when idle");
    c_rx: cover property ($rose(o_rx_on));
    c_sleep: cover property ($rose(o_sleep));
    c_cal: cover property ($rose(o_cal_busy));
endmodule : sdc_core_props
bind sdc_core sdc_core_props #(.CAL_FULL_A(CAL_FULL_A), .SYNTH_ON(SYNTH_ON)) sdc_core_props_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_serial_chip_select_n(i_serial_chip_select_n),
    .o_miso(o_miso), .o_xosc_on(o_xosc_on), .o_synth_on(o_synth_on), .o_rx_on(o_rx_on),
    .o_cal_busy(o_cal_busy), .o_sleep(o_sleep), .o_state(o_state));

// ### tb/sdc_host_model.sv
// Purpose: Serial master standing in for the microcontroller
// Assumes: Mode 0, MSB first, halves of 8 system clocks
// Notes:   Data line shows the inverse of the last bit between bytes
`timescale 1ns/1ps
module sdc_host_model (
    input  wire logic i_clk,
    output logic      o_sclk,                 // Serial clock, low when idle
    output logic      o_cs_n,                 // Select, active low
    output logic      o_mosi,                 // Serial data out
    input  wire logic i_miso                  // Serial data in
);
    initial {o_sclk, o_cs_n, o_mosi} = 3'b010;
    // Select change, then a gap for the device synchronisers
    task automatic sel(input logic v);
        o_cs_n = v;
        repeat (8) @(negedge i_clk);
    endtask : sel
    // One byte both ways; device answer sampled just before each rise
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
        begin
            o_mosi = d[i];
            repeat (8) @(negedge i_clk);
            q[i]   = i_miso;
            o_sclk = 1'b1;
            repeat (8) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        o_mosi = ~d[0];                       // Stale line must not look valid
        repeat (8) @(negedge i_clk);
    endtask : xbyte
endmodule : sdc_host_model

// ### tb/tb_top.sv
// Purpose: Directed checks of strobes, registers and calibration timing
// Assumes: Shortened calibration parameters 40/44/10/12/5
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ps
module tb_top;
    import sdc_pkg::*;
    logic       i_clk, i_reset, sclk, cs_n, mosi, miso, rx_valid;
    logic [7:0] rx_byte, st, q;               // Received byte, status, data
    logic       xosc_on, synth_on, rx_on, cal_busy, sleep;
    sdc_state_t state;
    int         n_mismatch, num_checks, cal_len;
    sdc_core #(.CAL_FULL(40), .CAL_FULL_A(44), .CAL_SHORT(10), .CAL_SHORT_A(12), .SYNTH_ON(5))
        sdc_core_inst (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk),
        .i_serial_chip_select_n(cs_n), .i_mosi(mosi), .o_miso(miso), .i_rx_valid(rx_valid),
        .i_rx_byte(rx_byte), .o_xosc_on(xosc_on), .o_synth_on(synth_on), .o_rx_on(rx_on),
        .o_cal_busy(cal_busy), .o_sleep(sleep), .o_state(state));
    sdc_host_model sdc_host_model_inst (.i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi), .i_miso(miso));
    initial
    begin
        i_clk = 0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Calibration length observed at the port
    always @(negedge i_clk) if (cal_busy === 1'b1) cal_len++;
    task automatic conclude();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Header plus one data byte
    task automatic acc(input logic [7:0] h, input logic [7:0] d);
        sdc_host_model_inst.sel(1'b0);
        sdc_host_model_inst.xbyte(h, st);
        sdc_host_model_inst.xbyte(d, q);
        sdc_host_model_inst.sel(1'b1);
    endtask : acc
    task automatic strobe(input logic [7:0] h);
        sdc_host_model_inst.sel(1'b0);
        sdc_host_model_inst.xbyte(h, st);
        sdc_host_model_inst.sel(1'b1);
    endtask : strobe
    // Bounded wait for a main state
    task automatic wait_st(input sdc_state_t s);
        for (int k = 0; k < 2000 && state !== s; k++) @(negedge i_clk);
        chk({5'h00, state}, {5'h00, s});
        if (state !== s) conclude();
    endtask : wait_st
    task automatic push(input logic [7:0] b);
        rx_valid = 1'b1;
        rx_byte  = b;
        @(negedge i_clk);
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    endtask : push
    task automatic cal_run(input logic [7:0] h, input sdc_state_t s, input int n);
        cal_len = 0;
        strobe(h);
        wait_st(s);
        chk(cal_len[7:0], n[7:0]);
    endtask : cal_run
    initial
    begin
        {i_reset, rx_valid, rx_byte, n_mismatch, num_checks, cal_len} = '0;
        i_reset = 1'b1;
        repeat (10) @(negedge i_clk);
        i_reset = 1'b0;
        repeat (4) @(negedge i_clk);
        acc(8'hAE, 8'h00); chk(st, 8'h00); chk(q, 8'h09);
        acc(8'h98, 8'h00); chk(q, 8'h00);
        acc(8'h10, 8'hA5); chk(q, 8'h00);
        acc(8'h90, 8'h00); chk(q, 8'hA5);
        acc(8'h1E, 8'h5A); acc(8'h9E, 8'h00); chk(q, 8'h00);
        acc(8'h75, 8'h03); acc(8'hF5, 8'h00); chk(q, 8'h00);
        strobe(8'h30); acc(8'h90, 8'h00); chk(q, 8'h00);
        cal_run(8'h33, SDC_IDLE, 10); chk({7'h00, synth_on}, 8'h00);
        acc(8'h23, 8'h20); cal_run(8'h33, SDC_IDLE, 40);
        acc(8'h2E, 8'h0B); cal_run(8'h33, SDC_IDLE, 44);
        acc(8'h18, 8'h10); cal_run(8'h34, SDC_RX, 44);
        push(8'h11); push(8'h22);
        strobe(8'h3D); chk(st, 8'h12);
        strobe(8'h31); chk(st, 8'h12); chk({5'h00, state}, {5'h00, SDC_RX});
        strobe(8'h36); wait_st(SDC_IDLE);
        acc(8'hBF, 8'h00); chk(q, 8'h11);
        acc(8'hBF, 8'h00); chk(q, 8'h22);
        cal_run(8'h34, SDC_RX, 44); push(8'h33); strobe(8'h36);
        strobe(8'h3A); acc(8'hFB, 8'h00); chk(q, 8'h00);
        sdc_host_model_inst.sel(1'b0);
        sdc_host_model_inst.xbyte(8'h32, st);
        chk({7'h00, xosc_on}, 8'h00);
        sdc_host_model_inst.sel(1'b1);
        wait_st(SDC_IDLE);
        sdc_host_model_inst.sel(1'b0);
        sdc_host_model_inst.xbyte(8'h39, st);
        chk({7'h00, sleep}, 8'h00);
        sdc_host_model_inst.sel(1'b1);
        chk({7'h00, sleep}, 8'h01);
        acc(8'hAE, 8'h00); chk(q, 8'h09);
        conclude();
    end
endmodule : tb_top
